/* File: hdl/sflash_pkg.sv */
// Shared constants, types and the opcode table of the serial flash front end.
package sflash_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths of the serial header, and the synchroniser depth.
  localparam int OPC_BITS   = 8;
  localparam int BYTE_BITS  = 8;
  localparam int ADDR_BYTES = 3;
  localparam int ADDR_BITS  = ADDR_BYTES * BYTE_BITS;
  localparam int ADDR_KEEP  = 21;
  localparam int SYNC_DEPTH = 2;

  // Reset values.
  localparam logic       CS_IDLE   = 1'b1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes the device understands.
  localparam logic [7:0] OPC_READ_MAX     = 8'h1b;
  localparam logic [7:0] OPC_READ_FAST    = 8'h0b;
  localparam logic [7:0] OPC_READ_SLOW    = 8'h03;
  localparam logic [7:0] OPC_READ_DUAL    = 8'h3b;
  localparam logic [7:0] OPC_ERASE_4K     = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K    = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K    = 8'hd8;
  localparam logic [7:0] OPC_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_ERASE_CHIP_B = 8'hc7;
  localparam logic [7:0] OPC_PROGRAM      = 8'h02;
  localparam logic [7:0] OPC_PROGRAM_DUAL = 8'ha2;
  localparam logic [7:0] OPC_SUSPEND      = 8'hb0;
  localparam logic [7:0] OPC_RESUME       = 8'hd0;
  localparam logic [7:0] OPC_WR_ENABLE    = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE   = 8'h04;
  localparam logic [7:0] OPC_PROTECT      = 8'h36;
  localparam logic [7:0] OPC_UNPROTECT    = 8'h39;
  localparam logic [7:0] OPC_RD_PROTECT   = 8'h3c;
  localparam logic [7:0] OPC_LOCKDOWN     = 8'h33;
  localparam logic [7:0] OPC_FREEZE_LOCK  = 8'h34;
  localparam logic [7:0] OPC_RD_LOCKDOWN  = 8'h35;
  localparam logic [7:0] OPC_OTP_PROGRAM  = 8'h9b;
  localparam logic [7:0] OPC_OTP_READ     = 8'h77;
  localparam logic [7:0] OPC_RD_STATUS    = 8'h05;
  localparam logic [7:0] OPC_WR_STATUS_1  = 8'h01;
  localparam logic [7:0] OPC_WR_STATUS_2  = 8'h31;
  localparam logic [7:0] OPC_SOFT_RESET   = 8'hf0;
  localparam logic [7:0] OPC_READ_ID      = 8'h9f;
  localparam logic [7:0] OPC_POWER_DOWN   = 8'hb9;
  localparam logic [7:0] OPC_POWER_UP     = 8'hab;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_IN   = 2'h1,
    DIR_OUT  = 2'h2
  } dir_t;

  typedef struct packed {
    logic       ok;
    logic       addr;
    logic [1:0] dummy;
    dir_t       dir;
    logic       dual;
  } cmd_info_t;

  typedef struct packed {
    logic [OPC_BITS-1:0]  opcode;
    logic [ADDR_KEEP-1:0] addr;
  } cmd_t;

  typedef enum logic [2:0] {
    LS_OPCODE = 3'h0,
    LS_ADDR   = 3'h1,
    LS_DUMMY  = 3'h3,
    LS_DATA   = 3'h2,
    LS_IGNORE = 3'h6
  } link_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Builds one table entry.
  function automatic cmd_info_t mk(input logic a, input logic [1:0] d,
                                   input dir_t r, input logic du);
    cmd_info_t i;
    i = '{ok: 1'b1, addr: a, dummy: d, dir: r, dual: du};
    return i;
  endfunction

  // Header shape of each opcode; unknown opcodes come back with ok low.
  function automatic cmd_info_t cmd_lookup(input logic [OPC_BITS-1:0] opc);
    cmd_info_t i;
    i = '{ok: 1'b0, addr: 1'b0, dummy: 2'h0, dir: DIR_NONE, dual: 1'b0};
    unique case (opc)
      OPC_READ_MAX, OPC_OTP_READ:    i = mk(1'b1, 2'h2, DIR_OUT, 1'b0);
      OPC_READ_FAST:                 i = mk(1'b1, 2'h1, DIR_OUT, 1'b0);
      OPC_READ_DUAL:                 i = mk(1'b1, 2'h1, DIR_OUT, 1'b1);
      OPC_READ_SLOW, OPC_RD_PROTECT,
      OPC_RD_LOCKDOWN:               i = mk(1'b1, 2'h0, DIR_OUT, 1'b0);
      OPC_PROGRAM, OPC_LOCKDOWN, OPC_FREEZE_LOCK,
      OPC_OTP_PROGRAM:               i = mk(1'b1, 2'h0, DIR_IN, 1'b0);
      OPC_PROGRAM_DUAL:              i = mk(1'b1, 2'h0, DIR_IN, 1'b1);
      OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K, OPC_PROTECT,
      OPC_UNPROTECT:                 i = mk(1'b1, 2'h0, DIR_NONE, 1'b0);
      OPC_RD_STATUS, OPC_READ_ID:    i = mk(1'b0, 2'h0, DIR_OUT, 1'b0);
      OPC_WR_STATUS_1, OPC_WR_STATUS_2,
      OPC_SOFT_RESET:                i = mk(1'b0, 2'h0, DIR_IN, 1'b0);
      OPC_ERASE_CHIP_A, OPC_ERASE_CHIP_B, OPC_SUSPEND, OPC_RESUME,
      OPC_WR_ENABLE, OPC_WR_DISABLE, OPC_POWER_DOWN,
      OPC_POWER_UP:                  i = mk(1'b0, 2'h0, DIR_NONE, 1'b0);
      default:                       i.ok = 1'b0;
    endcase
    return i;
  endfunction

endpackage

/* File: hdl/level_sync.sv */
// Two-stage synchroniser for levels entering the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module level_sync
  import sflash_pkg::*;
#(
  parameter int           WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule // level_sync
`default_nettype wire

/* File: hdl/toggle_event.sv */
// Turns toggles from the link clock into one-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none
module toggle_event
  import sflash_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] tgl,
  output logic      [WIDTH-1:0] pulse
);

  logic [WIDTH-1:0] tgl_sync;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic [WIDTH-1:0] pulse_reg;
  logic [WIDTH-1:0] pulse_next;

  level_sync #(.WIDTH(WIDTH), .RST_VAL('0)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (tgl),
    .q      (tgl_sync)
  );

  // Any change of a synchronised toggle is one event.
  always_comb begin
    prev_next  = tgl_sync;
    pulse_next = tgl_sync ^ prev_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg  <= '0;
      pulse_reg <= '0;
    end else begin
      prev_reg  <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;

endmodule // toggle_event
`default_nettype wire

/* File: hdl/sflash_frontend.sv */
// Serial command front end of a serial flash: framing, header and data pins.
`timescale 1ns/1ps
`default_nettype none
module sflash_frontend
  import sflash_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 cs_n,
  input  wire logic                 sck,
  input  wire logic                 si_in,
  output logic                      si_out,
  output logic                      si_oe,
  input  wire logic                 so_in,
  output logic                      so_out,
  output logic                      so_oe,
  output logic                      cmd_valid,
  output cmd_t                      cmd,
  output logic                      rx_valid,
  output logic [BYTE_BITS-1:0]      rx_data,
  output logic                      tx_req,
  input  wire logic [BYTE_BITS-1:0] tx_data,
  input  wire logic                 tx_load,
  output logic                      frame_active,
  output logic                      frame_end
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock: header and receive shifter, cleared by chip select.

  link_state_t          state_reg;
  link_state_t          state_next;
  logic [2:0]           bit_reg;
  logic [2:0]           bit_next;
  logic [1:0]           byte_reg;
  logic [1:0]           byte_next;
  logic [7:0]           shift_reg;
  logic [7:0]           shift_next;
  logic [15:0]          addr_reg;
  logic [15:0]          addr_next;
  cmd_info_t            info_reg;
  cmd_info_t            info_next;
  logic [OPC_BITS-1:0]  opc_reg;
  logic [OPC_BITS-1:0]  opc_next;
  logic                 dual_in;
  logic [1:0]           step;
  logic [3:0]           bit_sum;
  logic                 byte_done;
  cmd_info_t            opc_info;
  logic                 cmd_fire;
  logic                 rx_fire;
  logic [ADDR_BITS-1:0] full_addr;

  // Two-bit steps only while receiving dual-input program data.
  always_comb begin
    dual_in = (state_reg == LS_DATA) && (info_reg.dir == DIR_IN)
              && info_reg.dual;
    step    = dual_in ? 2'h2 : 2'h1;
    bit_sum = {1'b0, bit_reg} + {2'h0, step};
    byte_done = bit_sum[3];
    // Serial out pin carries the upper bit of each pair.
    shift_next = dual_in ? {shift_reg[5:0], so_in, si_in}
                         : {shift_reg[6:0], si_in};
    opc_info  = cmd_lookup(shift_next);
    full_addr = {addr_reg, shift_next};
  end

  // Header sequencer: opcode, address bytes, dummy bytes, then data.
  always_comb begin
    state_next = state_reg;
    bit_next   = bit_sum[2:0];
    byte_next  = byte_reg;
    addr_next  = addr_reg;
    info_next  = info_reg;
    opc_next   = opc_reg;
    cmd_fire   = 1'b0;
    rx_fire    = 1'b0;
    unique case (state_reg)
      LS_OPCODE: begin
        if (byte_done) begin
          opc_next  = shift_next;
          info_next = opc_info;
          if (!opc_info.ok) begin
            state_next = LS_IGNORE;
          end else if (opc_info.addr) begin
            state_next = LS_ADDR;
          end else begin
            cmd_fire   = 1'b1;
            state_next = LS_DATA;
          end
        end
      end
      LS_ADDR: begin
        if (byte_done) begin
          addr_next = full_addr[15:0];
          byte_next = byte_reg + 2'h1;
          if (byte_reg == 2'(ADDR_BYTES - 1)) begin
            cmd_fire  = 1'b1;
            byte_next = 2'h0;
            state_next = (info_reg.dummy != 2'h0) ? LS_DUMMY : LS_DATA;
          end
        end
      end
      LS_DUMMY: begin
        if (byte_done) begin
          byte_next = byte_reg + 2'h1;
          if (byte_next == info_reg.dummy) begin
            byte_next  = 2'h0;
            state_next = LS_DATA;
          end
        end
      end
      LS_DATA: begin
        rx_fire = byte_done && (info_reg.dir == DIR_IN);
      end
      LS_IGNORE: begin
        bit_next = 3'h0;
      end
      default: begin
        state_next = LS_IGNORE;
      end
    endcase
  end

  // A high chip select clears the header machine; idle level is moot.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      state_reg <= LS_OPCODE;
      bit_reg   <= 3'h0;
      byte_reg  <= 2'h0;
      shift_reg <= BYTE_ZERO;
      addr_reg  <= 16'h0000;
      info_reg  <= '0;
      opc_reg   <= BYTE_ZERO;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      byte_reg  <= byte_next;
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      info_reg  <= info_next;
      opc_reg   <= opc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock: words held across frames and their event toggles.

  cmd_t                 cmd_hold_reg;
  cmd_t                 cmd_hold_next;
  logic [BYTE_BITS-1:0] rx_hold_reg;
  logic [BYTE_BITS-1:0] rx_hold_next;
  logic                 cmd_tgl_reg;
  logic                 cmd_tgl_next;
  logic                 rx_tgl_reg;
  logic                 rx_tgl_next;

  // Held words stay put until the next event, long after the toggle lands.
  always_comb begin
    cmd_hold_next = cmd_hold_reg;
    rx_hold_next  = rx_hold_reg;
    cmd_tgl_next  = cmd_tgl_reg ^ cmd_fire;
    rx_tgl_next   = rx_tgl_reg ^ rx_fire;
    if (cmd_fire) begin
      cmd_hold_next.opcode = opc_info.ok && (state_reg == LS_OPCODE)
                             ? shift_next : opc_reg;
      cmd_hold_next.addr   = (state_reg == LS_ADDR)
                             ? full_addr[ADDR_KEEP-1:0]
                             : '0;
    end
    if (rx_fire) begin
      rx_hold_next = shift_next;
    end
  end

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      cmd_hold_reg <= '0;
      rx_hold_reg  <= BYTE_ZERO;
      cmd_tgl_reg  <= 1'b0;
      rx_tgl_reg   <= 1'b0;
    end else begin
      cmd_hold_reg <= cmd_hold_next;
      rx_hold_reg  <= rx_hold_next;
      cmd_tgl_reg  <= cmd_tgl_next;
      rx_tgl_reg   <= rx_tgl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock, falling edge: output shifter and pin enables.

  logic [BYTE_BITS-1:0] tx_hold_reg;
  logic [2:0]           obit_reg;
  logic [2:0]           obit_next;
  logic [7:0]           oshift_reg;
  logic [7:0]           oshift_next;
  logic                 so_out_reg;
  logic                 so_out_next;
  logic                 so_oe_reg;
  logic                 so_oe_next;
  logic                 si_out_reg;
  logic                 si_out_next;
  logic                 si_oe_reg;
  logic                 si_oe_next;
  logic                 take_tgl_reg;
  logic                 take_tgl_next;
  logic                 drive;
  logic                 dual_out;
  logic [7:0]           obyte;

  // A fresh byte is fetched from the system side at each byte boundary.
  always_comb begin
    drive    = (state_reg == LS_DATA) && (info_reg.dir == DIR_OUT);
    dual_out = drive && info_reg.dual;
    obyte    = (obit_reg == 3'h0) ? tx_hold_reg : oshift_reg;
    obit_next   = obit_reg;
    oshift_next = oshift_reg;
    so_out_next = 1'b0;
    si_out_next = 1'b0;
    so_oe_next  = 1'b0;
    si_oe_next  = 1'b0;
    take_tgl_next = take_tgl_reg;
    if (drive) begin
      so_out_next = obyte[7];
      si_out_next = obyte[6];
      so_oe_next  = 1'b1;
      si_oe_next  = dual_out;
      oshift_next = dual_out ? {obyte[5:0], 2'h0} : {obyte[6:0], 1'b0};
      obit_next   = obit_reg + (dual_out ? 3'h2 : 3'h1);
      take_tgl_next = take_tgl_reg ^ (obit_reg == 3'h0);
    end
  end

  // Falling-edge outputs; chip select high floats both pins at once.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      obit_reg   <= 3'h0;
      oshift_reg <= BYTE_ZERO;
      so_out_reg <= 1'b0;
      so_oe_reg  <= 1'b0;
      si_out_reg <= 1'b0;
      si_oe_reg  <= 1'b0;
    end else begin
      obit_reg   <= obit_next;
      oshift_reg <= oshift_next;
      so_out_reg <= so_out_next;
      so_oe_reg  <= so_oe_next;
      si_out_reg <= si_out_next;
      si_oe_reg  <= si_oe_next;
    end
  end

  // The byte-taken toggle must survive frame ends.
  always_ff @(negedge sck or negedge arst_n) begin
    if (!arst_n) begin
      take_tgl_reg <= 1'b0;
    end else begin
      take_tgl_reg <= take_tgl_next;
    end
  end

  assign so_out = so_out_reg;
  assign so_oe  = so_oe_reg;
  assign si_out = si_out_reg;
  assign si_oe  = si_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // System clock: crossings and user side.

  logic                 cs_sync;
  logic [2:0]           ev;
  cmd_info_t            core_info;
  logic                 cs_prev_reg;
  logic                 cs_prev_next;
  logic                 cmd_valid_reg;
  logic                 cmd_valid_next;
  cmd_t                 cmd_reg;
  cmd_t                 cmd_next;
  logic                 rx_valid_reg;
  logic                 rx_valid_next;
  logic [BYTE_BITS-1:0] rx_data_reg;
  logic [BYTE_BITS-1:0] rx_data_next;
  logic                 tx_req_reg;
  logic                 tx_req_next;
  logic [BYTE_BITS-1:0] tx_hold_next;
  logic                 frame_end_reg;
  logic                 frame_end_next;
  logic                 frame_active_reg;
  logic                 frame_active_next;

  level_sync #(.WIDTH(1), .RST_VAL(CS_IDLE)) u_cs_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (cs_n),
    .q      (cs_sync)
  );

  toggle_event #(.WIDTH(3)) u_events (
    .clk    (clk),
    .arst_n (arst_n),
    .tgl    ({take_tgl_reg, rx_tgl_reg, cmd_tgl_reg}),
    .pulse  (ev)
  );

  // Events become registered pulses; a read asks for bytes ahead of need.
  always_comb begin
    core_info      = cmd_lookup(cmd_hold_reg.opcode);
    cs_prev_next   = cs_sync;
    cmd_valid_next = ev[0];
    cmd_next       = ev[0] ? cmd_hold_reg : cmd_reg;
    rx_valid_next  = ev[1];
    rx_data_next   = ev[1] ? rx_hold_reg : rx_data_reg;
    tx_req_next    = ev[2] || (ev[0] && (core_info.dir == DIR_OUT));
    tx_hold_next   = tx_load ? tx_data : tx_hold_reg;
    frame_end_next = cs_sync && !cs_prev_reg;
    frame_active_next = !cs_sync;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev_reg   <= CS_IDLE;
      cmd_valid_reg <= 1'b0;
      cmd_reg       <= '0;
      rx_valid_reg  <= 1'b0;
      rx_data_reg   <= BYTE_ZERO;
      tx_req_reg    <= 1'b0;
      tx_hold_reg   <= BYTE_ZERO;
      frame_end_reg <= 1'b0;
      frame_active_reg <= 1'b0;
    end else begin
      cs_prev_reg   <= cs_prev_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_reg       <= cmd_next;
      rx_valid_reg  <= rx_valid_next;
      rx_data_reg   <= rx_data_next;
      tx_req_reg    <= tx_req_next;
      tx_hold_reg   <= tx_hold_next;
      frame_end_reg <= frame_end_next;
      frame_active_reg <= frame_active_next;
    end
  end

  assign cmd_valid    = cmd_valid_reg;
  assign cmd          = cmd_reg;
  assign rx_valid     = rx_valid_reg;
  assign rx_data      = rx_data_reg;
  assign tx_req       = tx_req_reg;
  assign frame_active = frame_active_reg;
  assign frame_end    = frame_end_reg;

endmodule // sflash_frontend
`default_nettype wire

/* File: test/sflash_frontend_props.sv */
// Concurrent checks on the ports of the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module sflash_frontend_props
  import sflash_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       cs_n,
  input wire logic       si_oe,
  input wire logic       so_oe,
  input wire logic       cmd_valid,
  input wire cmd_t       cmd,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       tx_req,
  input wire logic       frame_active,
  input wire logic       frame_end
);
  // All checks run on the system clock and pause during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  float_idle_a: assert property (cs_n |-> !so_oe && !si_oe)
    else $error("Pins driven while deselected.");
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("Header event longer than one cycle.");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("Data event longer than one cycle.");
  end_pulse_a: assert property (frame_end |=> !frame_end)
    else $error("Frame end longer than one cycle.");
  cmd_hold_a: assert property (!cmd_valid |-> $stable(cmd))
    else $error("Header changed without an event.");
  rx_hold_a: assert property (!rx_valid |-> $stable(rx_data))
    else $error("Write byte changed without an event.");
  dual_pins_a: assert property (si_oe |-> so_oe && cmd.opcode == OPC_READ_DUAL)
    else $error("Input pin driven outside dual read.");
  in_free_a: assert property (so_oe |-> cmd.opcode != OPC_PROGRAM_DUAL)
    else $error("Output pin driven in dual program.");
  frame_oe_a: assert property (so_oe |-> frame_active)
    else $error("Output pin driven outside a frame.");
  fast_req_a: assert property (cmd_valid && cmd.opcode == OPC_READ_FAST |-> tx_req)
    else $error("Read header without a byte request.");

  // Main scenarios.
  hdr_c: cover property (cmd_valid);
  wr_c: cover property (rx_valid);
  dual_c: cover property (si_oe);
endmodule // sflash_frontend_props
`default_nettype wire

/* File: test/sflash_host.sv */
// Host model that drives the link in clock mode 0 or 3.
`timescale 1ns/1ps
`default_nettype none
module sflash_host (
  output logic      cs_n = 1'b0,
  output logic      sck  = 1'b0,
  output logic      si_d = 1'b0,
  output logic      so_d = 1'b0,
  input  wire logic si_w,
  input  wire logic so_w
);
  logic idle = 1'b0;

  // Raises select once at start so the link logic begins from its clear state.
  initial #1 cs_n = 1'b1;

  // Selects the device with the clock resting at its idle level.
  task automatic start(input logic mode);
    idle = mode;
    sck = mode;
    #40 cs_n = 1'b0;
    #40;
  endtask

  // Shifts one byte MSB first; the released pin toggles every bit.
  task automatic xfer(input logic [7:0] b, input logic dual,
                      output logic [7:0] r);
    int n;
    n = dual ? 4 : 8;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      so_d = dual ? b[7-2*i] : ~so_d;
      si_d = dual ? b[6-2*i] : b[7-i];
      #40 sck = 1'b1;
      r = dual ? {r[5:0], so_w, si_w} : {r[6:0], so_w};
      #40;
    end
  endtask

  // Deselects and rests before the next frame.
  task automatic stop();
    #40 cs_n = 1'b1;
    sck = idle;
    #160;
  endtask
endmodule // sflash_host
`default_nettype wire

/* File: test/sflash_frontend_tb.sv */
// Testbench of the serial flash front end with a host on the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
  n_checks++; \
  if ((e) !== (a)) begin \
    miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); \
  end
module sflash_frontend_tb
  import sflash_pkg::*;
;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_load = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  int         miscompares = 0;
  int         n_checks = 0;
  int         n_cmd = 0;
  int         n_rx = 0;
  int         n_end = 0;
  wire logic  cs_n, sck, si_d, so_d, si_out, si_oe, so_out, so_oe;
  wire logic  cmd_valid, rx_valid, tx_req, frame_active, frame_end;
  wire cmd_t  cmd;
  wire logic [7:0] rx_data;
  // The device wins a pin while it enables it; otherwise the host drives.
  wire logic  si_w = si_oe ? si_out : si_d;
  wire logic  so_w = so_oe ? so_out : so_d;

  sflash_frontend u_sflash_frontend (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si_in(si_w),
    .si_out(si_out), .si_oe(si_oe), .so_in(so_w), .so_out(so_out),
    .so_oe(so_oe), .cmd_valid(cmd_valid), .cmd(cmd), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_req(tx_req), .tx_data(tx_data),
    .tx_load(tx_load), .frame_active(frame_active), .frame_end(frame_end)
  );
  sflash_host u_sflash_host (
    .cs_n(cs_n), .sck(sck), .si_d(si_d), .so_d(so_d), .si_w(si_w),
    .so_w(so_w)
  );

  // Clock of 50 ns.
  initial forever #25 clk = ~clk;

  // Counts header and write events.
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (rx_valid === 1'b1) n_rx <= n_rx + 1;
    if (frame_end === 1'b1) n_end <= n_end + 1;
  end

  // Answers every byte request in the following cycle.
  always @(negedge clk) begin
    tx_load <= (tx_req === 1'b1);
    tx_data <= tx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selects and sends an opcode and the first nb address bytes.
  task automatic send(input logic m, input logic [7:0] opc,
                      input logic [23:0] a, input int nb);
    logic [7:0] r;
    u_sflash_host.start(m);
    u_sflash_host.xfer(opc, 1'b0, r);
    for (int i = 0; i < nb; i++)
      u_sflash_host.xfer(a[23-8*i -: 8], 1'b0, r);
  endtask

  // Ends a frame and lets the events cross.
  task automatic fin();
    u_sflash_host.stop();
    repeat (8) @(negedge clk);
  endtask

  // Truncated address gives no header.
  task automatic t_short();
    int c;
    c = n_cmd;
    send(1'b0, OPC_PROGRAM, 24'h123456, 2);
    fin();
    `CHK("short hdr", c, n_cmd)
  endtask

  // Top address bits are dropped; counters start clean after a short frame.
  task automatic t_erase();
    int c;
    int e;
    c = n_cmd + 1;
    e = n_end + 1;
    send(1'b0, OPC_ERASE_4K, 24'hff1234, 3);
    `CHK("in frame", 1'b1, frame_active)
    fin();
    `CHK("hdr count", c, n_cmd)
    `CHK("opcode", OPC_ERASE_4K, cmd.opcode)
    `CHK("addr", 21'h1f1234, cmd.addr)
    `CHK("frame end", e, n_end)
    `CHK("out of frame", 1'b0, frame_active)
  endtask

  // Opcode with no address gives its header at once, address zero.
  task automatic t_noaddr();
    int c;
    c = n_cmd + 1;
    send(1'b1, OPC_WR_ENABLE, 24'h000000, 0);
    fin();
    `CHK("noaddr count", c, n_cmd)
    `CHK("noaddr opcode", OPC_WR_ENABLE, cmd.opcode)
    `CHK("noaddr addr", 21'h000000, cmd.addr)
  endtask

  // Unknown opcode: later bits and bytes make no events.
  task automatic t_bad();
    int c;
    int w;
    logic [7:0] r;
    c = n_cmd;
    w = n_rx;
    send(1'b0, 8'hff, 24'h02a202, 3);
    u_sflash_host.xfer(8'h02, 1'b0, r);
    fin();
    `CHK("bad hdr", c, n_cmd)
    `CHK("bad rx", w, n_rx)
  endtask

  // Reads one byte after the dummies, in mode 0 or 3.
  task automatic t_read(input logic m, input logic [7:0] opc, input int nd,
                        input logic dual, input logic [7:0] v);
    logic [7:0] r;
    tx_byte = v;
    send(m, opc, 24'h000010, 3);
    repeat (nd) u_sflash_host.xfer(8'h00, 1'b0, r);
    u_sflash_host.xfer(8'h00, dual, r);
    fin();
    `CHK("read", v, r)
  endtask

  // Dual program byte arrives as one write event.
  task automatic t_dual_in();
    int w;
    logic [7:0] r;
    w = n_rx + 1;
    send(1'b0, OPC_PROGRAM_DUAL, 24'h000100, 3);
    u_sflash_host.xfer(8'h5c, 1'b1, r);
    fin();
    `CHK("rx count", w, n_rx)
    `CHK("rx data", 8'h5c, rx_data)
  endtask

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Stops a hung run.
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_short();
    t_erase();
    t_noaddr();
    t_bad();
    t_read(1'b1, OPC_READ_FAST, 1, 1'b0, 8'ha5);
    t_read(1'b0, OPC_READ_MAX, 2, 1'b0, 8'h3c);
    t_read(1'b0, OPC_READ_DUAL, 1, 1'b1, 8'h96);
    t_dual_in();
    end_of_test();
  end
endmodule // sflash_frontend_tb

bind sflash_frontend sflash_frontend_props u_sflash_frontend_props (
  .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .si_oe(si_oe), .so_oe(so_oe),
  .cmd_valid(cmd_valid), .cmd(cmd), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_req(tx_req), .frame_active(frame_active), .frame_end(frame_end)
);
`default_nettype wire
